// [slp_host_model.sv]
// Host controller and external FIFO model that feeds transmit words to the port.
`timescale 1ns/10ps
module slp_host_model (
    input wire logic clk_sys, // System clock.
    input wire logic depth_expansion_select, // High: behave as an external FIFO.
    input wire logic transmit_ready, // High when the port takes a write.
    output logic transmit_write_strobe, // Write strobe, polarity by mode.
    output logic [slp_pkg::DATA_W-1:0] transmit_parallel_word, // Word presented.
    output logic transmit_command_data_select // Command flag presented.
);
    import slp_pkg::*;
    logic act = 1'b0; // High while a write is being requested.
    // The strobe is active high for a FIFO feed and active low for a controller feed.
    assign transmit_write_strobe = act ? depth_expansion_select : !depth_expansion_select;
    // Data lines start at a known level.
    initial begin
        transmit_parallel_word = '0;
        transmit_command_data_select = 1'b0;
    end
    // Requests one write, holds it until taken, then withdraws the data.
    task automatic write(input logic [DATA_W-1:0] w, input logic c);
        logic rdy;
        @(posedge clk_sys);
        act <= 1'b1;
        if (!depth_expansion_select) begin
            // A controller presents the word together with its strobe.
            transmit_parallel_word <= w;
            transmit_command_data_select <= c;
        end
        // Ready moves only after rising edges, so the falling edge shows what is sampled.
        do begin
            @(negedge clk_sys);
            rdy = transmit_ready;
            @(posedge clk_sys);
        end while (rdy !== 1'b1);
        act <= 1'b0;
        if (depth_expansion_select) begin
            // A FIFO presents the word only in the cycle after the strobe.
            transmit_parallel_word <= w;
            transmit_command_data_select <= c;
            @(posedge clk_sys);
        end
        // Released data is inverted so a capture in the wrong cycle is caught.
        transmit_parallel_word <= ~w;
        transmit_command_data_select <= ~c;
    endtask
endmodule

// [slp_pkg.sv]
// Shared constants and types for the serial link parallel port.
package slp_pkg;

    // Width of one parallel data word in the widest character mode.
    localparam int unsigned DATA_W = 10;

    // Width of the serial symbol shifter, sized for the longest symbol.
    localparam int unsigned SYM_W = 12;

    // Width of the serial bit counters.
    localparam int unsigned CNT_W = 4;

    // Serial bits per character in 8-bit character mode.
    localparam logic [CNT_W-1:0] SYM_LEN_8 = 4'ha;

    // Serial bits per character in 10-bit character mode.
    localparam logic [CNT_W-1:0] SYM_LEN_10 = 4'hc;

    // Last bit of a symbol is collected when the counter shows this value.
    localparam logic [CNT_W-1:0] CNT_LAST = 4'h1;

    // Counter value that marks an idle shifter.
    localparam logic [CNT_W-1:0] CNT_IDLE = 4'h0;

    // Leading bit of every symbol; the receiver frames on it.
    localparam logic START_MARK = 1'b1;

    // Padding that left-aligns a short symbol in the shifter.
    localparam logic [1:0] SYM_PAD_8 = 2'h0;

    // Default depth of the receive FIFO in words.
    localparam int unsigned FIFO_DEPTH_DEF = 8;

    // Bit positions of the synchronised configuration pins.
    localparam int unsigned CFG_DEPTH = 0;
    localparam int unsigned CFG_WIDTH8 = 1;
    localparam int unsigned CFG_BYP_N = 2;
    localparam int unsigned CFG_MULT = 3;
    localparam int unsigned CFG_RANGE = 4;
    localparam int unsigned CFG_W = 5;

    // Transmit capture sequencer states.
    typedef enum logic [0:0] {
        SLP_CAP_IDLE = 1'b0,
        SLP_CAP_ARMED = 1'b1
    } slp_cap_t;

    // Receive framer states.
    typedef enum logic [0:0] {
        SLP_RX_HUNT = 1'b0,
        SLP_RX_COLLECT = 1'b1
    } slp_rx_t;

endpackage

// [slp_rx_des.sv]
// Receive NRZI decoder, framer and deserializer.
`timescale 1ns/10ps
module slp_rx_des (
    input wire logic clk_sys, // System clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic serial_in, // NRZI serial line from the pin.
    input wire logic width8, // High selects 8-bit character mode.
    output logic [slp_pkg::DATA_W-1:0] word_out, // Last received word.
    output logic cmd_out, // Command flag of the last word.
    output logic word_valid // One-cycle pulse with each new word.
);
    import slp_pkg::*;

    // Whole state of the deserializer.
    typedef struct packed {
        logic s1; // First synchroniser stage.
        logic s2; // Second synchroniser stage.
        logic prev; // Line level one bit time ago.
        slp_rx_t state; // Framer state.
        logic [SYM_W-1:0] shift; // Collected symbol bits.
        logic [CNT_W-1:0] cnt; // Bits still to collect.
        logic [DATA_W-1:0] word; // Decoded word.
        logic cmd; // Decoded command flag.
        logic valid; // New word pulse.
    } slp_des_st_t;

    slp_des_st_t r; // Registered state.
    slp_des_st_t nxt; // Next state.
    logic bit_now; // Decoded bit of this bit time.
    logic [SYM_W-1:0] full; // Symbol including the bit of this cycle.

    // A transition within the bit time is a one, no transition a zero.
    assign bit_now = r.s2 ^ r.prev;
    assign full = {r.shift[SYM_W-2:0], bit_now};

    // Hunt for the start mark, then collect the rest of the symbol.
    always_comb begin
        nxt = r;
        nxt.s1 = serial_in;
        nxt.s2 = r.s1;
        nxt.prev = r.s2;
        nxt.valid = 1'b0;
        case (r.state)
            SLP_RX_HUNT: begin
                // A one on an idle line starts a symbol.
                if (bit_now == START_MARK) begin
                    nxt.state = SLP_RX_COLLECT;
                    nxt.shift = {{(SYM_W-1){1'b0}}, START_MARK};
                    nxt.cnt = (width8 ? SYM_LEN_8 : SYM_LEN_10) - CNT_LAST;
                end
            end
            SLP_RX_COLLECT: begin
                nxt.shift = full;
                nxt.cnt = r.cnt - CNT_LAST;
                if (r.cnt == CNT_LAST) begin
                    // Undo the group ordering of the transmitter.
                    nxt.state = SLP_RX_HUNT;
                    nxt.valid = 1'b1;
                    if (width8) begin
                        nxt.word = {2'h0, full[8:5], full[3:0]};
                        nxt.cmd = full[4];
                    end else begin
                        nxt.word = {full[4], full[10:6], full[3:0]};
                        nxt.cmd = full[5];
                    end
                end
            end
            default: begin
                nxt.state = SLP_RX_HUNT;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign word_out = r.word;
    assign cmd_out = r.cmd;
    assign word_valid = r.valid;
endmodule

// [slp_top.sv]
// Parallel host port of the serial link: transmit capture and receive FIFO.
// Summary of operation
// - Depth expansion: capture word one cycle later
// - Controller mode: capture word with low strobe
// - Receive outputs hold when inhibited or empty
// - Each cycle with low read strobe, outputs driven and FIFO not empty reads
// - Available flag high unless receive FIFO empty
// - No FIFO reads while receive outputs high-Z
// - Bypassed with multiplier high forces high range
// - Characters are 10 or 12 bits
// - Parallel bits ordered into two groups
// - Serial line uses NRZI coding both ways
// - Leftmost bit of leading group first
`timescale 1ns/10ps
module slp_top #(
    parameter int unsigned FIFO_DEPTH = slp_pkg::FIFO_DEPTH_DEF // Receive FIFO depth.
) (
    input wire logic clk_sys, // System clock, 250 MHz.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic depth_expansion_select, // High: fed by external FIFO.
    input wire logic transmit_write_strobe, // Write strobe, polarity by mode.
    input wire logic [slp_pkg::DATA_W-1:0] transmit_parallel_word, // Word to send.
    input wire logic transmit_command_data_select, // High sends a command.
    output logic transmit_ready, // High when a write is taken.
    input wire logic char_width_select, // High: 8-bit characters.
    output logic serial_out, // NRZI serial output.
    input wire logic serial_in, // NRZI serial input.
    input wire logic receive_read_strobe_n, // Read strobe, active low.
    input wire logic receive_outputs_hiz, // High floats receive outputs.
    output logic receive_output_enable, // High while outputs drive.
    output logic [slp_pkg::DATA_W-1:0] receive_parallel_word, // Word read.
    output logic receive_command_data_flag, // Command flag of word read.
    output logic receive_word_available_flag, // High when FIFO holds a word.
    output logic receive_overflow, // Pulse when a word is dropped.
    input wire logic fifo_bypass_select_n, // Active low; with the multiplier high it forces the upper range.
    input wire logic reference_clock_input_multiplier_select, // Reference multiplier select.
    input wire logic baud_range_select, // High: 100 to 200 MBaud.
    output logic effective_high_baud_range // Range in use, high is upper.
);
    import slp_pkg::*;

    // Pointer and fill counter widths of the receive FIFO.
    localparam int unsigned PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int unsigned FILL_W = $clog2(FIFO_DEPTH + 1);
    // Fill level at which the FIFO is full.
    localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(FIFO_DEPTH);
    // Fill level of one word.
    localparam logic [FILL_W-1:0] FILL_ONE = FILL_W'(1);
    // Width of one FIFO entry: the word plus its command flag.
    localparam int unsigned ENTRY_W = DATA_W + 1;

    // Whole state of the port.
    typedef struct packed {
        logic [CFG_W-1:0] cfg_s1; // First stage of the pin synchronisers.
        logic [CFG_W-1:0] cfg_s2; // Second stage, read by the logic.
        logic [1:0] warm; // Ones shift in after reset; top bit marks settled configuration.
        slp_cap_t cap; // Transmit capture sequencer.
        logic [DATA_W-1:0] tx_word; // Captured transmit word.
        logic tx_cmd; // Captured command select.
        logic tx_load; // Pulse that hands the word to the serializer.
        logic [FIFO_DEPTH-1:0][ENTRY_W-1:0] mem; // Receive FIFO storage.
        logic [PTR_W-1:0] wr_ptr; // Next entry to write.
        logic [PTR_W-1:0] rd_ptr; // Next entry to read.
        logic [FILL_W-1:0] fill; // Words held.
        logic [DATA_W-1:0] rx_word; // Receive output word.
        logic rx_cmd; // Receive output command flag.
        logic overflow; // Dropped word pulse.
        logic range_hi; // Baud range in use.
    } slp_top_st_t;

    slp_top_st_t r; // Registered state.
    slp_top_st_t nxt; // Next state.
    logic [CFG_W-1:0] cfg_pins; // Configuration pins gathered.
    logic [CFG_W-1:0] cfg; // Synchronised configuration.
    logic ser_ready; // Serializer idle.
    logic [DATA_W-1:0] des_word; // Word from the deserializer.
    logic des_cmd; // Command flag from the deserializer.
    logic des_valid; // New word from the deserializer.
    logic read_ok; // A read is taken this cycle.
    logic push_ok; // A received word is stored this cycle.
    logic [ENTRY_W-1:0] head; // Entry at the read pointer.
    logic strobe_hit; // Write strobe active for the selected mode.

    // Configuration pins come from outside and pass two flip-flops first.
    assign cfg_pins[CFG_DEPTH] = depth_expansion_select;
    assign cfg_pins[CFG_WIDTH8] = char_width_select;
    assign cfg_pins[CFG_BYP_N] = fifo_bypass_select_n;
    assign cfg_pins[CFG_MULT] = reference_clock_input_multiplier_select;
    assign cfg_pins[CFG_RANGE] = baud_range_select;
    assign cfg = r.cfg_s2;

    // A write is taken only when the serializer and sequencer are free.
    // Writes wait until the synchronised mode is valid, since the idle strobe
    // level of one feed mode is the active level of the other.
    assign transmit_ready = r.warm[1] && ser_ready && !r.tx_load && (r.cap == SLP_CAP_IDLE);

    // The external FIFO enables with a high strobe, a controller with a low one.
    assign strobe_hit = cfg[CFG_DEPTH] ? transmit_write_strobe : !transmit_write_strobe;

    // Reads are blocked while the outputs float and while the FIFO is empty.
    assign read_ok = !receive_read_strobe_n && !receive_outputs_hiz && (r.fill != '0);

    // A full FIFO still accepts a word when a read frees an entry.
    assign push_ok = des_valid && ((r.fill != FILL_FULL) || read_ok);
    assign head = r.mem[r.rd_ptr];

    // Next state of the whole port.
    always_comb begin
        nxt = r;
        nxt.cfg_s1 = cfg_pins;
        nxt.cfg_s2 = r.cfg_s1;
        nxt.warm = {r.warm[0], 1'b1};
        nxt.tx_load = 1'b0;
        nxt.overflow = des_valid && !push_ok;

        // Transmit capture sequencer.
        case (r.cap)
            SLP_CAP_IDLE: begin
                if (transmit_ready && strobe_hit) begin
                    if (cfg[CFG_DEPTH]) begin
                        // The external FIFO presents its word one cycle later.
                        nxt.cap = SLP_CAP_ARMED;
                    end else begin
                        // The controller presents its word with the strobe.
                        nxt.tx_word = transmit_parallel_word;
                        nxt.tx_cmd = transmit_command_data_select;
                        nxt.tx_load = 1'b1;
                    end
                end
            end
            SLP_CAP_ARMED: begin
                // Take the word that the external FIFO now presents.
                nxt.tx_word = transmit_parallel_word;
                nxt.tx_cmd = transmit_command_data_select;
                nxt.tx_load = 1'b1;
                nxt.cap = SLP_CAP_IDLE;
            end
            default: begin
                nxt.cap = SLP_CAP_IDLE;
            end
        endcase

        // Store a received word at the write pointer.
        if (push_ok) begin
            nxt.mem[r.wr_ptr] = {des_cmd, des_word};
            nxt.wr_ptr = r.wr_ptr + 1'b1;
        end

        // Outputs change only on a taken read, otherwise they hold.
        if (read_ok) begin
            nxt.rx_word = head[DATA_W-1:0];
            nxt.rx_cmd = head[DATA_W];
            nxt.rd_ptr = r.rd_ptr + 1'b1;
        end

        // Fill level follows pushes and reads.
        if (push_ok && !read_ok) begin
            nxt.fill = r.fill + FILL_ONE;
        end else if (read_ok && !push_ok) begin
            nxt.fill = r.fill - FILL_ONE;
        end

        // Bypassed with the multiplier high forces the upper range.
        nxt.range_hi = cfg[CFG_RANGE] || (!cfg[CFG_BYP_N] && cfg[CFG_MULT]);
    end

    // State register.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    // Serializer for the transmit path.
    slp_tx_ser u_tx (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .load(r.tx_load),
        .word(r.tx_word),
        .cmd(r.tx_cmd),
        .width8(cfg[CFG_WIDTH8]),
        .ready(ser_ready),
        .serial_out(serial_out)
    );

    // Deserializer for the receive path.
    slp_rx_des u_rx (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .serial_in(serial_in),
        .width8(cfg[CFG_WIDTH8]),
        .word_out(des_word),
        .cmd_out(des_cmd),
        .word_valid(des_valid)
    );

    // Outputs.
    assign receive_output_enable = !receive_outputs_hiz;
    assign receive_parallel_word = r.rx_word;
    assign receive_command_data_flag = r.rx_cmd;
    assign receive_word_available_flag = (r.fill != '0);
    assign receive_overflow = r.overflow;
    assign effective_high_baud_range = r.range_hi;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Steps of a depth expansion write: strobe taken, then word captured.
    sequence seq_depth_strobe;
        cfg[CFG_DEPTH] && transmit_ready && transmit_write_strobe;
    endsequence

    sequence seq_depth_capture;
        ##1 (r.cap == SLP_CAP_ARMED) ##1 (r.tx_load && r.tx_word == $past(transmit_parallel_word));
    endsequence

    chk_depth_capture: assert property (seq_depth_strobe |-> seq_depth_capture)
        else $error("depth expansion word not captured one cycle late");
    chk_ctrl_capture: assert property ((!cfg[CFG_DEPTH] && transmit_ready && !transmit_write_strobe) |=> r.tx_load && r.tx_word == $past(transmit_parallel_word))
        else $error("controller word not captured with its strobe");
    chk_hold_data: assert property ((!read_ok) |=> $stable(receive_parallel_word) && $stable(receive_command_data_flag))
        else $error("receive outputs changed without a read");
    chk_read_take: assert property ((!receive_read_strobe_n && !receive_outputs_hiz && receive_word_available_flag) |=> receive_parallel_word == $past(head[DATA_W-1:0]))
        else $error("low read strobe did not deliver the head word");
    chk_flag_empty: assert property ((read_ok && r.fill == FILL_ONE && !des_valid) |=> !receive_word_available_flag)
        else $error("available flag stayed high on an empty FIFO");
    chk_flag_fill: assert property ((!receive_word_available_flag && des_valid) |=> receive_word_available_flag)
        else $error("available flag not raised after a stored word");
    chk_hiz_block: assert property (receive_outputs_hiz |=> $stable(r.rd_ptr) && $stable(receive_parallel_word))
        else $error("FIFO read while outputs floated");
    chk_forced_range: assert property ((!cfg[CFG_BYP_N] && cfg[CFG_MULT]) |=> effective_high_baud_range)
        else $error("upper baud range not forced in bypass");
endmodule

// [slp_top_bench.sv]
// Self-checking testbench of the serial link parallel port in serial loopback.
`timescale 1ns/10ps
module slp_top_bench;
    import slp_pkg::*;
    logic clk_sys = 1'b0; // System clock, 4 ns period.
    logic rstn = 1'b0; // Reset, active low.
    logic depth = 1'b0; // Depth expansion select.
    logic width8 = 1'b0; // Character width select.
    logic strobe_n = 1'b1; // Receive read strobe, active low.
    logic hiz = 1'b0; // Receive outputs floated.
    logic byp_n = 1'b1; // FIFO bypass select, active low.
    logic mult = 1'b0; // Reference multiplier select.
    logic range = 1'b0; // Baud range select.
    wire logic strobe, tx_cmd, ready, ser, oe, rx_cmd, avail, ovf, eff;
    wire logic [DATA_W-1:0] tx_word, rx_word;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int n_ovf = 0; // Dropped word pulses seen.
    logic [31:0] seed = 32'h0001_548b; // Fixed seed for repeatable runs.
    logic [11:0] line_q[$]; // Symbols expected on the serial line.
    logic [10:0] rx_q[$]; // Command flag and word expected from the FIFO.
    logic prev = 1'b0; // Previous line level for NRZI decoding.
    logic b; // Decoded line bit.
    logic [11:0] sh = '0; // Symbol being collected from the line.
    int cnt = 0; // Bits still to collect, zero while hunting.

    // Clock generator.
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    slp_host_model i_host (.clk_sys(clk_sys), .depth_expansion_select(depth),
        .transmit_ready(ready), .transmit_write_strobe(strobe),
        .transmit_parallel_word(tx_word), .transmit_command_data_select(tx_cmd));

    slp_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .depth_expansion_select(depth),
        .transmit_write_strobe(strobe), .transmit_parallel_word(tx_word),
        .transmit_command_data_select(tx_cmd), .transmit_ready(ready),
        .char_width_select(width8), .serial_out(ser), .serial_in(ser),
        .receive_read_strobe_n(strobe_n), .receive_outputs_hiz(hiz),
        .receive_output_enable(oe), .receive_parallel_word(rx_word),
        .receive_command_data_flag(rx_cmd), .receive_word_available_flag(avail),
        .receive_overflow(ovf), .fifo_bypass_select_n(byp_n),
        .reference_clock_input_multiplier_select(mult), .baud_range_select(range),
        .effective_high_baud_range(eff));

    // Next value of the xorshift generator.
    function automatic logic [31:0] rnd(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Line symbol of a word, right aligned, leading bit first.
    function automatic logic [11:0] line_sym(input logic [9:0] w, input logic c, input logic w8);
        if (w8) begin
            return {2'h0, START_MARK, w[7:4], c, w[3:0]};
        end
        return {START_MARK, w[8:4], c, w[9], w[3:0]};
    endfunction

    // Compares a seen value with the expected one and counts the result.
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            end_sim();
        end
    end

    // Decodes the NRZI line on falling edges and checks each framed symbol.
    always @(negedge clk_sys) begin
        if (!rstn) begin
            prev = 1'b0;
            cnt = 0;
        end else begin
            if (ovf === 1'b1) begin
                n_ovf++;
            end
            b = ser ^ prev;
            prev = ser;
            if (cnt == 0 && b) begin
                sh = 12'h001;
                cnt = width8 ? 9 : 11;
            end else if (cnt > 0) begin
                sh = {sh[10:0], b};
                cnt--;
                if (cnt == 0) begin
                    check("line_symbol", sh, line_q.pop_front());
                end
            end
        end
    end

    // Resets the port with the chosen character width and feed mode.
    task automatic do_reset(input logic w8, input logic dp);
        @(posedge clk_sys);
        rstn <= 1'b0;
        width8 <= w8;
        depth <= dp;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask

    // Sends six words (nine in the last mode, overfilling the FIFO), then reads back.
    task automatic run_mode(input logic w8, input logic dp);
        logic [9:0] w;
        logic c;
        logic [10:0] last;
        int nw;
        nw = (w8 && dp) ? 9 : 6;
        do_reset(w8, dp);
        for (int i = 0; i < nw; i++) begin
            seed = rnd(seed);
            w = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : seed[9:0];
            if (w8) begin
                w[9:8] = 2'h0;
            end
            c = seed[12];
            line_q.push_back(line_sym(w, c, w8));
            if (i < FIFO_DEPTH_DEF) begin
                rx_q.push_back({c, w});
            end
            i_host.write(w, c);
        end
        for (int k = 0; k < 200 && line_q.size() > 0; k++) begin
            @(posedge clk_sys);
        end
        repeat (8) @(posedge clk_sys);
        #1 check("available", avail, 12'h001);
        last = {rx_cmd, rx_word};
        @(posedge clk_sys);
        hiz <= 1'b1;
        strobe_n <= 1'b0;
        @(posedge clk_sys);
        #1 check("output_enable", oe, 12'h000);
        check("hiz_word", last, {rx_cmd, rx_word});
        @(posedge clk_sys);
        hiz <= 1'b0;
        // Back-to-back reads, one word every cycle.
        for (int i = 0; i < nw && i < FIFO_DEPTH_DEF; i++) begin
            @(posedge clk_sys);
            #1 check("read_word", {rx_cmd, rx_word}, rx_q.pop_front());
        end
        check("overflow", n_ovf[11:0], {11'h000, w8 & dp});
        last = {rx_cmd, rx_word};
        check("empty", avail, 12'h000);
        @(posedge clk_sys);
        #1 check("empty_hold", {rx_cmd, rx_word}, last);
        @(posedge clk_sys);
        strobe_n <= 1'b1;
    endtask

    // Main sequence: every width and feed mode, then every range setting.
    initial begin
        for (int m = 0; m < 4; m++) begin
            run_mode(m[0], m[1]);
        end
        for (int m = 0; m < 8; m++) begin
            @(posedge clk_sys);
            byp_n <= m[0];
            mult <= m[1];
            range <= m[2];
            repeat (5) @(posedge clk_sys);
            #1 check("range", eff, {11'h000, m[2] | (!m[0] & m[1])});
        end
        end_sim();
    end
endmodule

// [slp_tx_ser.sv]
// Transmit symbol builder, serializer and NRZI line encoder.
`timescale 1ns/10ps
module slp_tx_ser (
    input wire logic clk_sys, // System clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic load, // One-cycle request to send a word.
    input wire logic [slp_pkg::DATA_W-1:0] word, // Word to send.
    input wire logic cmd, // High marks a command character.
    input wire logic width8, // High selects 8-bit character mode.
    output logic ready, // High while idle and able to load.
    output logic serial_out // NRZI serial line level.
);
    import slp_pkg::*;

    // Whole state of the serializer.
    typedef struct packed {
        logic [SYM_W-1:0] shift; // Symbol bits still to send, MSB first.
        logic [CNT_W-1:0] left; // Bits still to send.
        logic line; // Present line level.
    } slp_ser_st_t;

    slp_ser_st_t r; // Registered state.
    slp_ser_st_t nxt; // Next state.
    logic [9:0] sym8; // Symbol of an 8-bit mode character.
    logic [SYM_W-1:0] sym12; // Symbol of a 10-bit mode character.

    // The two groups are built in the order the bits go out on the line.
    assign sym8 = {START_MARK, word[7:4], cmd, word[3:0]};
    assign sym12 = {START_MARK, word[8:4], cmd, word[9], word[3:0]};

    // Shift one bit per cycle; a one toggles the line, a zero leaves it.
    always_comb begin
        nxt = r;
        if (r.left != CNT_IDLE) begin
            // Leftmost bit of the leading group goes first.
            if (r.shift[SYM_W-1]) begin
                nxt.line = ~r.line;
            end
            nxt.shift = {r.shift[SYM_W-2:0], 1'b0};
            nxt.left = r.left - CNT_LAST;
        end else if (load) begin
            // Short symbols are left-aligned so the same shifter serves both.
            nxt.shift = width8 ? {sym8, SYM_PAD_8} : sym12;
            nxt.left = width8 ? SYM_LEN_8 : SYM_LEN_10;
        end
    end

    // State register.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign ready = (r.left == CNT_IDLE);
    assign serial_out = r.line;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    chk_len_eight_bit: assert property ((load && ready && width8) |-> ##11 ready and ##10 !ready)
        else $error("8-bit character did not take 10 bit times");
    chk_len_ten_bit: assert property ((load && ready && !width8) |-> ##13 ready and ##12 !ready)
        else $error("10-bit character did not take 12 bit times");
    chk_nrzi_toggle: assert property ((!ready) |=> (serial_out != $past(serial_out)) == $past(r.shift[SYM_W-1]))
        else $error("line level does not follow NRZI coding");
    chk_lead_group_first: assert property ((load && ready && width8) |=> r.shift[SYM_W-1 -: 5] == {START_MARK, $past(word[7:4])})
        else $error("leading group not placed first in shifter");
endmodule
